// File: design/flash_sector_protection_pkg.sv
// shared constants and types for the sector protection block
// Function
// - low write-protect pin guards boundary sector
// - floating write-protect pin counts as high
// - either sector bit zero blocks program, erase
// - guard zero freezes all persistent bits
// - persistent method: guard one at reset, clear-only
// - password method: guard zero at reset, clearable
// - exact 64-bit password match sets guard
// - one-time lock bits fix method permanently
// - delivered state: persistent bits all erased
// - single volatile guard over persistent bits
// - program bits singly, erase all together
// - toggle bit flips per status read while an operation runs
// - guard zero: persistent-bit program, erase time out unchanged
// - overlay status read returns sector bit
// - dynamic set writes zero, clear writes one
// - dynamic bits changeable regardless of guard
// - unprotected only when both bits one
// - dynamic bits unprotected after any reset
// - method bits at lock bits 1, 2
// - programming both method bits aborts
package flash_sector_protection_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PW_LO  = 8'h08;
  localparam logic [7:0] OFS_PW_HI  = 8'h0C;
  localparam logic [7:0] OFS_LOCK   = 8'h10;
  localparam logic [7:0] OFS_PSB    = 8'h14;
  localparam logic [7:0] OFS_DYN    = 8'h18;
  localparam logic [7:0] OFS_PROT   = 8'h1C;
  localparam logic [7:0] OFS_SECT   = 8'h20;

  // lock word layout and reset values
  localparam logic [15:0] LOCK_RESET     = 16'hFEFE;
  localparam logic [15:0] LOCK_PROG_MASK = 16'h0E47;
  localparam int unsigned LK_PERSIST     = 1;
  localparam int unsigned LK_PASSWORD    = 2;
  localparam logic [63:0] PW_RESET       = 64'hFFFF_FFFF_FFFF_FFFF;

  // timing, nominal figures
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned WORD_PROG_US  = 200;
  localparam int unsigned SECT_ERASE_MS = 500;
  localparam int unsigned PW_CHECK_US   = 100;
  localparam int unsigned PROG_CYC  = WORD_PROG_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_CYC = SECT_ERASE_MS * (CLK_HZ / 1_000);
  localparam int unsigned PW_CYC    = PW_CHECK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W   = 25;
  typedef logic [TIMER_W-1:0] tcnt_t;

  typedef enum logic [3:0] {
    CMD_NOP       = 4'h0,
    CMD_PSB_PROG  = 4'h1,
    CMD_PSB_ERASE = 4'h2,
    CMD_DYN_SET   = 4'h3,
    CMD_DYN_CLR   = 4'h4,
    CMD_GUARD_CLR = 4'h5,
    CMD_PW_UNLOCK = 4'h6,
    CMD_PW_PROG   = 4'h7,
    CMD_LOCK_PROG = 4'h8,
    CMD_OVL_ENTER = 4'h9,
    CMD_OVL_EXIT  = 4'hA,
    CMD_PSB_READ  = 4'hB
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PROG   = 2'b01,
    ST_ERASE  = 2'b10,
    ST_UNLOCK = 2'b11
  } op_state_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  sector;
    logic [3:0]  spare;
    cmd_t        code;
  } cmd_word_t;

  typedef struct packed {
    logic [25:0] zero;
    logic        fail;
    logic        ovl;
    logic        method_pw;
    logic        guard;
    logic        toggle;
    logic        busy;
  } status_t;

endpackage

// File: design/op_timer.sv
// countdown timer for embedded operations
`timescale 1ns/100ps
`default_nettype none
module op_timer
  import flash_sector_protection_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  abort,
  input  wire logic  start,
  input  wire tcnt_t len,
  output logic       done
);
  tcnt_t cnt_reg;

  // load on start, count to zero; abort drops any run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (abort) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= len;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - tcnt_t'(1);
    end
  end

  assign done = (cnt_reg == tcnt_t'(1)) && !abort;
endmodule // op_timer
`default_nettype wire

// File: design/sector_prot_map.sv
// per-sector effective protection from bits and pin
`timescale 1ns/100ps
`default_nettype none
module sector_prot_map #(
  parameter int unsigned SECTORS = 32,
  parameter bit          WP_TOP  = 1'b0
) (
  input  wire logic [SECTORS-1:0] psb,
  input  wire logic [SECTORS-1:0] dyn,
  input  wire logic               wp_n,
  output logic      [SECTORS-1:0] prot
);
  localparam int unsigned BND = WP_TOP ? SECTORS - 1 : 0;

  // both bits one means open; pin low closes the boundary sector
  always_comb begin
    prot = ~(psb & dyn);
    // pad pull-up keeps a floating pin high, so only a driven low guards
    if (!wp_n) begin
      prot[BND] = 1'b1;
    end
  end
endmodule // sector_prot_map
`default_nettype wire

// File: design/flash_sector_protection.sv
// sector protection core with apb register access
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module flash_sector_protection
  import flash_sector_protection_pkg::*;
#(
  parameter int unsigned SECTORS      = 32,
  parameter bit          WP_TOP       = 1'b0,
  parameter int unsigned PROG_CYCLES  = PROG_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned PW_CYCLES    = PW_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               hw_reset_n,
  input  wire logic               wp_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic      [SECTORS-1:0] sector_protected,
  output logic                    embedded_busy
);
  localparam int unsigned SW  = $clog2(SECTORS);
  localparam int unsigned BND = WP_TOP ? SECTORS - 1 : 0;

  op_state_t          state_reg;
  cmd_t               op_code_reg;
  logic [SW-1:0]      op_sec_reg;
  logic [15:0]        op_data_reg;
  logic [SECTORS-1:0] psb_reg;
  logic [SECTORS-1:0] dyn_reg;
  logic [SECTORS-1:0] prot_reg;
  logic [SECTORS-1:0] prot_comb;
  logic [15:0]        lock_reg;
  logic [63:0]        pw_reg;
  logic [63:0]        entry_reg;
  logic               guard_reg;
  logic               toggle_reg;
  logic               fail_reg;
  logic               ovl_reg;
  logic               psb_stat_reg;
  logic [31:0]        prdata_reg;
  logic [31:0]        rd_next;
  cmd_word_t          cw;
  tcnt_t              op_len;
  status_t            stat;
  logic               setup;
  logic               rd;
  logic               wr;
  logic               cmd_go;
  logic               op_start;
  logic               op_done;
  logic               sec_ok;
  logic               lock_abort;
  logic               method_pw;
  logic               pw_match;
  logic [SW-1:0]      sec_idx;

  // widen a sector vector to one bus word
  function automatic logic [31:0] pad32(input logic [SECTORS-1:0] v);
    pad32 = '0;
    pad32[SECTORS-1:0] = v;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      OFS_CMD, OFS_STATUS, OFS_PW_LO, OFS_PW_HI, OFS_LOCK,
      OFS_PSB, OFS_DYN, OFS_PROT, OFS_SECT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // once a method bit is programmed, neither method bit may change
  function automatic logic [15:0] lock_mask(input logic [15:0] lk);
    lock_mask = LOCK_PROG_MASK;
    if (!lk[LK_PERSIST] || !lk[LK_PASSWORD]) begin
      lock_mask[LK_PERSIST]  = 1'b0;
      lock_mask[LK_PASSWORD] = 1'b0;
    end
  endfunction

  // apb phase decode; zero wait states
  assign setup   = psel && !penable;
  assign rd      = psel && penable && !pwrite;
  assign wr      = psel && penable && pwrite && addr_ok(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata  = prdata_reg;

  // command decode; commands while busy are dropped
  assign cw         = cmd_word_t'(pwdata);
  assign cmd_go     = wr && (paddr == OFS_CMD) && (state_reg == ST_IDLE);
  assign sec_ok     = {1'b0, cw.sector} < 9'(SECTORS);
  assign sec_idx    = cw.sector[SW-1:0];
  assign method_pw  = !lock_reg[LK_PASSWORD];
  assign pw_match   = (entry_reg == pw_reg);
  assign lock_abort = cmd_go && (cw.code == CMD_LOCK_PROG)
                      && !cw.data[LK_PERSIST] && !cw.data[LK_PASSWORD];

  // commands that run as timed embedded operations
  always_comb begin
    op_len   = tcnt_t'(PROG_CYCLES);
    op_start = 1'b0;
    if (cmd_go) begin
      case (cw.code)
        CMD_PSB_PROG:  op_start = sec_ok;
        CMD_PSB_ERASE: begin
          op_start = 1'b1;
          op_len   = tcnt_t'(ERASE_CYCLES);
        end
        CMD_PW_UNLOCK: begin
          op_start = 1'b1;
          op_len   = tcnt_t'(PW_CYCLES);
        end
        CMD_PW_PROG:   op_start = 1'b1;
        CMD_LOCK_PROG: op_start = !lock_abort;
        default:       op_start = 1'b0;
      endcase
    end
  end

  op_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .abort   (!hw_reset_n),
    .start   (op_start),
    .len     (op_len),
    .done    (op_done)
  );

  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      op_code_reg <= CMD_NOP;
      op_sec_reg  <= '0;
      op_data_reg <= '0;
    end else if (!hw_reset_n) begin
      state_reg <= ST_IDLE;
    end else if (op_start) begin
      op_code_reg <= cw.code;
      op_sec_reg  <= sec_idx;
      op_data_reg <= cw.data;
      case (cw.code)
        CMD_PSB_ERASE: state_reg <= ST_ERASE;
        CMD_PW_UNLOCK: state_reg <= ST_UNLOCK;
        default:       state_reg <= ST_PROG;
      endcase
    end else if (op_done) begin
      state_reg <= ST_IDLE;
    end
  end

  // persistent bits: non-volatile, so hardware reset leaves them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psb_reg <= '1;
    end else if (op_done && guard_reg) begin
      // controller does its own preprogram and verify inside the erase time
      if (op_code_reg == CMD_PSB_ERASE) begin
        psb_reg <= '1;
      end else if (op_code_reg == CMD_PSB_PROG) begin
        psb_reg[op_sec_reg] <= 1'b0;
      end
    end
  end

  // dynamic bits: volatile, writable whatever the guard says
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dyn_reg <= '1;
    end else if (!hw_reset_n) begin
      dyn_reg <= '1;
    end else if (cmd_go && sec_ok && (cw.code == CMD_DYN_SET)) begin
      dyn_reg[sec_idx] <= 1'b0;
    end else if (cmd_go && sec_ok && (cw.code == CMD_DYN_CLR)) begin
      dyn_reg[sec_idx] <= 1'b1;
    end
  end

  // the one guard bit; power-on default lock word means persistent method
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_reg <= 1'b1;
    end else if (!hw_reset_n) begin
      guard_reg <= !method_pw;
    end else if (cmd_go && (cw.code == CMD_GUARD_CLR)) begin
      guard_reg <= 1'b0;
    end else if (op_done && (op_code_reg == CMD_PW_UNLOCK) && method_pw && pw_match) begin
      guard_reg <= 1'b1;
    end
  end

  // one-time lock word: bits only go from one to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= LOCK_RESET;
    end else if (op_done && (op_code_reg == CMD_LOCK_PROG)) begin
      lock_reg <= lock_reg & (op_data_reg | ~lock_mask(lock_reg));
    end
  end

  // hidden password; programming closes once password method is chosen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_reg <= PW_RESET;
    end else if (op_done && (op_code_reg == CMD_PW_PROG) && !method_pw) begin
      pw_reg <= pw_reg & entry_reg;
    end
  end

  // password entry words; write-only so the value never reads back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_reg <= PW_RESET;
    end else if (wr && (paddr == OFS_PW_LO)) begin
      entry_reg[31:0] <= pwdata;
    end else if (wr && (paddr == OFS_PW_HI)) begin
      entry_reg[63:32] <= pwdata;
    end
  end

  // failure flag; a set outranks the clear of a new command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_reg <= 1'b0;
    end else if (lock_abort) begin
      fail_reg <= 1'b1;
    end else if (op_done && (op_code_reg == CMD_PW_UNLOCK) && !(method_pw && pw_match)) begin
      fail_reg <= 1'b1;
    end else if (op_done && !guard_reg
                 && ((op_code_reg == CMD_PSB_PROG) || (op_code_reg == CMD_PSB_ERASE))) begin
      fail_reg <= 1'b1;
    end else if (cmd_go) begin
      fail_reg <= 1'b0;
    end
  end

  // overlay entry and sector status latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_reg      <= 1'b0;
      psb_stat_reg <= 1'b0;
    end else if (!hw_reset_n) begin
      ovl_reg <= 1'b0;
    end else if (cmd_go && (cw.code == CMD_OVL_ENTER)) begin
      ovl_reg <= 1'b1;
    end else if (cmd_go && (cw.code == CMD_OVL_EXIT)) begin
      ovl_reg <= 1'b0;
    end else if (cmd_go && ovl_reg && sec_ok && (cw.code == CMD_PSB_READ)) begin
      psb_stat_reg <= psb_reg[sec_idx];
    end
  end

  // toggle flips on each status read while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= 1'b0;
    end else if (rd && (paddr == OFS_STATUS) && (state_reg != ST_IDLE)) begin
      toggle_reg <= !toggle_reg;
    end
  end

  sector_prot_map #(
    .SECTORS (SECTORS),
    .WP_TOP  (WP_TOP)
  ) u_map (
    .psb  (psb_reg),
    .dyn  (dyn_reg),
    .wp_n (wp_n),
    .prot (prot_comb)
  );

  // registered protection view, one cycle behind the bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= '0;
    end else begin
      prot_reg <= prot_comb;
    end
  end

  assign sector_protected = prot_reg;
  assign embedded_busy    = (state_reg != ST_IDLE);

  // read mux, sampled in the setup cycle so pready can stay high
  always_comb begin
    stat           = '0;
    stat.fail      = fail_reg;
    stat.ovl       = ovl_reg;
    stat.method_pw = method_pw;
    stat.guard     = guard_reg;
    stat.toggle    = toggle_reg;
    stat.busy      = (state_reg != ST_IDLE);
    case (paddr)
      OFS_STATUS: rd_next = stat;
      OFS_LOCK:   rd_next = {16'h0000, lock_reg};
      OFS_PSB:    rd_next = pad32(psb_reg);
      OFS_DYN:    rd_next = pad32(dyn_reg);
      OFS_PROT:   rd_next = pad32(prot_reg);
      OFS_SECT:   rd_next = {31'h0000_0000, psb_stat_reg && ovl_reg};
      default:    rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup && !pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wp_guard_a: assert property (!wp_n |=> sector_protected[BND])
    else $error("boundary sector open while write-protect low");

  // checks the registered output, so a broken map or capture path trips it
  both_bits_a: assert property (
    ((~($past(psb_reg) & $past(dyn_reg))) & ~sector_protected) == '0)
    else $error("sector open with a zero protection bit");

  guard_freeze_a: assert property (!guard_reg |=> psb_reg == $past(psb_reg))
    else $error("persistent bits changed with guard zero");

  persist_hold_a: assert property (!method_pw && !guard_reg && hw_reset_n |=> !guard_reg)
    else $error("guard set again in persistent method");

  hw_reset_guard_a: assert property (!hw_reset_n |=> guard_reg == !$past(method_pw))
    else $error("guard wrong after hardware reset");

  unlock_match_a: assert property ($rose(guard_reg) && $past(hw_reset_n)
    |-> $past(pw_match) && $past(method_pw))
    else $error("guard set without password match");

  lock_abort_a: assert property (lock_abort |=> fail_reg && lock_reg == $past(lock_reg)
    && state_reg == ST_IDLE)
    else $error("dual method program not aborted");

  toggle_read_a: assert property (rd && paddr == OFS_STATUS && state_reg != ST_IDLE
    |=> toggle_reg != $past(toggle_reg))
    else $error("toggle bit did not flip on status read");

  dyn_set_a: assert property (cmd_go && sec_ok && cw.code == CMD_DYN_SET && hw_reset_n
    |=> !dyn_reg[$past(sec_idx)] ##1 sector_protected[$past(sec_idx, 2)])
    else $error("dynamic set did not protect sector");

  unlock_ok_c: cover property (op_done && op_code_reg == CMD_PW_UNLOCK && pw_match);
  erase_done_c: cover property (op_done && op_code_reg == CMD_PSB_ERASE && guard_reg);
  abort_c: cover property (lock_abort);
  blocked_prog_c: cover property (op_done && op_code_reg == CMD_PSB_PROG && !guard_reg);
endmodule // flash_sector_protection
`default_nettype wire

// File: verification/cmd_host.sv
// apb host model that issues command and register transfers
`timescale 1ns/100ps
`default_nettype none
module cmd_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // setup then access, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not keep its last value
  endtask
endmodule // cmd_host
`default_nettype wire

// File: verification/flash_sector_protection_bench.sv
// self-checking bench for the sector protection block
`timescale 1ns/100ps
`default_nettype none
module flash_sector_protection_bench;
  import flash_sector_protection_pkg::*;
  localparam int unsigned NS = 8;
  logic          pclk, presetn, hw_reset_n, wp_n;
  logic          psel, penable, pwrite, pready, pslverr, embedded_busy;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, q, pw_lo, pw_hi;
  logic [NS-1:0] sector_protected, m_psb, m_dyn;
  logic          e, t, m_guard, m_pw;
  int            errors, n_compared, seed, s;

  // short counts keep timed operations brief
  flash_sector_protection #(.SECTORS(NS), .WP_TOP(1'b0), .PROG_CYCLES(5),
    .ERASE_CYCLES(20), .PW_CYCLES(7)) u_flash_sector_protection (
    .pclk(pclk), .presetn(presetn), .hw_reset_n(hw_reset_n), .wp_n(wp_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sector_protected(sector_protected), .embedded_busy(embedded_busy));

  cmd_host u_cmd_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    u_cmd_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic cmd(input cmd_t c, input int sc = 0, input logic [15:0] d = 16'hFFFF);
    u_cmd_host.xfer(1'b1, OFS_CMD, {d, 8'(sc), 4'h0, c}, q, e);
  endtask

  // model: protected unless both bits one, pin adds sector 0
  function automatic logic [31:0] exp_prot();
    logic [NS-1:0] p;
    p = ~(m_psb & m_dyn);
    p[0] = p[0] | ~wp_n;
    return 32'(p);
  endfunction

  task automatic chk_state();
    rd(OFS_PROT);
    chk("prot reg", q, exp_prot());
    chk("prot pins", 32'(sector_protected), exp_prot());
    rd(OFS_STATUS);
    chk("guard", 32'(q[2]), 32'(m_guard));
    chk("method", 32'(q[3]), 32'(m_pw));
  endtask

  // poll status under a bound; the answer time is the design's own
  task automatic wait_idle();
    int k;
    k = 0;
    rd(OFS_STATUS);
    while (q[0] !== 1'b0 && k < 100) begin
      rd(OFS_STATUS);
      k++;
    end
    chk("op done", 32'(q[0]), 32'h0);
    chk("busy pin", 32'(embedded_busy), 32'h0);
  endtask

  task automatic hreset();
    @(posedge pclk);
    hw_reset_n <= 1'b0;
    @(posedge pclk);
    hw_reset_n <= 1'b1;
    m_dyn = '1;
    m_guard = ~m_pw;
  endtask

  initial begin
    seed = 36073;
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    hw_reset_n = 1'b1;
    wp_n = 1'b1;
    m_psb = '1;
    m_dyn = '1;
    m_guard = 1'b1;
    m_pw = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_state();
    rd(OFS_LOCK);
    chk("lock reset", q, 32'(LOCK_RESET));
    // pin only changes while no operation runs
    wp_n <= 1'b0;
    chk_state();
    wp_n <= 1'b1;
    chk_state();
    // random dynamic set and clear
    repeat (6) begin
      s = $unsigned($random(seed)) % NS;
      if ($random(seed) & 1) begin
        cmd(CMD_DYN_SET, s);
        m_dyn[s] = 1'b0;
      end else begin
        cmd(CMD_DYN_CLR, s);
        m_dyn[s] = 1'b1;
      end
      chk_state();
    end
    // program one persistent bit and read it through the overlay
    s = $unsigned($random(seed)) % NS;
    cmd(CMD_PSB_PROG, s);
    wait_idle();
    m_psb[s] = 1'b0;
    chk_state();
    cmd(CMD_OVL_ENTER);
    cmd(CMD_PSB_READ, s);
    rd(OFS_SECT);
    chk("overlay bit", 32'(q[0]), 32'h0);
    cmd(CMD_PSB_READ, s ^ 1);
    rd(OFS_SECT);
    chk("overlay open", 32'(q[0]), 32'h1);
    cmd(CMD_OVL_EXIT);
    // guard cleared once bits are set up; erase must fail
    cmd(CMD_GUARD_CLR);
    m_guard = 1'b0;
    cmd(CMD_PSB_ERASE);
    rd(OFS_STATUS);
    t = q[1];
    chk("busy bit", 32'(q[0]), 32'h1);
    chk("busy high", 32'(embedded_busy), 32'h1);
    rd(OFS_STATUS);
    chk("toggle", 32'(q[1]), {31'h0, ~t});
    wait_idle();
    chk("erase fail", 32'(q[5]), 32'h1);
    cmd(CMD_DYN_SET, s ^ 1);
    m_dyn[s ^ 1] = 1'b0;
    chk_state();
    hreset();
    chk_state();
    cmd(CMD_PSB_ERASE);
    wait_idle();
    m_psb = '1;
    chk_state();
    // both method bits in one program aborts
    cmd(CMD_LOCK_PROG, 0, 16'hFFF9);
    rd(OFS_STATUS);
    chk("both fail", 32'(q[5]), 32'h1);
    rd(OFS_LOCK);
    chk("lock kept", q, 32'(LOCK_RESET));
    // choose password method with a random password
    pw_lo = $random(seed);
    pw_hi = $random(seed);
    u_cmd_host.xfer(1'b1, OFS_PW_LO, pw_lo, q, e);
    u_cmd_host.xfer(1'b1, OFS_PW_HI, pw_hi, q, e);
    cmd(CMD_PW_PROG);
    wait_idle();
    cmd(CMD_LOCK_PROG, 0, 16'hFFFB);
    wait_idle();
    rd(OFS_LOCK);
    chk("lock pw", q, 32'h0000_FEFA);
    m_pw = 1'b1;
    hreset();
    chk_state();
    u_cmd_host.xfer(1'b1, OFS_PW_LO, pw_lo ^ 32'h1, q, e);
    cmd(CMD_PW_UNLOCK);
    wait_idle();
    chk("bad pw", 32'(q[5]), 32'h1);
    chk_state();
    u_cmd_host.xfer(1'b1, OFS_PW_LO, pw_lo, q, e);
    cmd(CMD_PW_UNLOCK);
    wait_idle();
    m_guard = 1'b1;
    chk_state();
    cmd(CMD_GUARD_CLR);
    m_guard = 1'b0;
    chk_state();
    // method choice is now permanent
    cmd(CMD_LOCK_PROG, 0, 16'hFFFD);
    wait_idle();
    rd(OFS_LOCK);
    chk("lock frozen", q, 32'h0000_FEFA);
    rd(8'h40);
    chk("unmapped", {31'h0, e}, 32'h1);
    tally_and_finish();
  end
endmodule // flash_sector_protection_bench
`default_nettype wire
